// >>> rtl/charger_status_fault_regs.sv
// Purpose: Status, fault, mask and identification registers on the serial port.
// Assumes: Serial master obeys the two-wire protocol; no clock stretching.
// Notes: The register pointer auto-increments after every data byte.
`timescale 1ns/10ps
module charger_status_fault_regs
#(
  parameter logic [6:0] TARGET_ADDR = charger_regs_pkg::TARGET_ADDR_DEF
)
(
  input  wire logic                                     clock,
  input  wire logic                                     rst,
  input  wire logic                                     scl,
  input  wire logic                                     sdaIn,
  output logic                                          sdaOut,
  output logic                                          sdaOe,
  input  wire charger_regs_pkg::charger_conditions_type conditions,
  output logic                                          vinLimitIrqPulse,
  output logic                                          iinLimitIrqPulse,
  output logic                                          defaultsRestore
);
  import charger_regs_pkg::*;

  localparam int CW = $bits(charger_conditions_type);

  logic [CW-1:0]          condSync;
  logic [1:0]             busSync;
  charger_conditions_type cond;
  logic                   sclPrev_reg;
  logic                   sdaPrev_reg;
  serial_state_type       state_reg;
  serial_state_type       state_next;
  logic [2:0]             bitCnt_reg;
  logic                   gotByte_reg;
  logic [7:0]             shift_reg;
  logic [7:0]             txShift_reg;
  logic [7:0]             txNext;
  logic [7:0]             pointer_reg;
  logic                   readMode_reg;
  logic                   masterAck_reg;
  logic                   sdaDrive_reg;
  logic                   vinMask_reg;
  logic                   iinMask_reg;
  logic                   restore_reg;
  logic [3:0]             restoreCnt_reg;
  logic                   vinPrev_reg;
  logic                   iinPrev_reg;
  logic                   vinIrq_reg;
  logic                   iinIrq_reg;
  source_state_type       srcState;
  fault_report_type       faultRep;
  limit_state_type        limitState;
  reset_id_type           resetId;
  logic [7:0]             readData;

  line_sync #(.WIDTH(CW)) condSyncInst
  (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (conditions),
    .syncOut (condSync)
  );

  line_sync #(.WIDTH(2)) busSyncInst
  (
    .clock   (clock),
    .rst     (rst),
    .asyncIn ({scl, sdaIn}),
    .syncOut (busSync)
  );

  assign cond = charger_conditions_type'(condSync);

  // source type codes, no current limit here
  function automatic logic [2:0] sourceCode(input charger_conditions_type c);
    logic [2:0] code;
    code = SRC_NONE;
    if (c.otgActive)
      code = SRC_OTG;
    else if (!c.inputAttached)
      code = SRC_NONE;
    else if (!c.detectVariant)
      code = c.sourceSelectPin ? SRC_SDP : SRC_ADAPTER;
    else
    begin
      case (c.detectedKind)
        KIND_SDP:     code = SRC_SDP;
        KIND_CDP:     code = SRC_CDP;
        KIND_DCP:     code = SRC_DCP;
        KIND_UNKNOWN: code = SRC_UNKNOWN;
        KIND_NONSTD:  code = SRC_NONSTD;
        default:      code = SRC_NONE;
      endcase
    end
    return code;
  endfunction

  function automatic logic [1:0] phaseCode(input charger_conditions_type c);
    logic [1:0] code;
    code = PHASE_IDLE;
    if (c.chargeDone)
      code = PHASE_DONE;
    else if (!c.charging)
      code = PHASE_IDLE;
    else if (c.belowPrecharge)
      code = PHASE_PRE;
    else
      code = PHASE_FAST;
    return code;
  endfunction

  function automatic logic [1:0] faultCode(input charger_conditions_type c);
    logic [1:0] code;
    code = FAULT_NONE;
    if (c.inputFault)
      code = FAULT_INPUT;
    else if (c.thermalShutdown)
      code = FAULT_THERMAL;
    else if (c.safetyTimerExpired)
      code = FAULT_TIMER;
    return code;
  endfunction

  function automatic logic [2:0] zoneCode(input charger_conditions_type c);
    logic [2:0] code;
    code = ZONE_NORMAL;
    if (c.zoneHot)
      code = ZONE_HOT;
    else if (c.zoneCold)
      code = ZONE_COLD;
    else if (c.boostMode)
      code = ZONE_NORMAL;
    else if (c.zoneWarm)
      code = ZONE_WARM;
    else if (c.zoneCool)
      code = ZONE_COOL;
    return code;
  endfunction

  assign srcState.sourceType = sourceCode(cond);
  assign srcState.phase      = phaseCode(cond);
  assign srcState.supplyOk   = cond.powerGood;
  assign srcState.thermalReg = cond.thermalReg;
  assign srcState.sysFloorReg = cond.sysFloorReg;

  assign faultRep.wdtExpiry   = cond.wdtExpired;
  assign faultRep.otgFault    = cond.boostFault;
  assign faultRep.chargeFault = faultCode(cond);
  assign faultRep.batteryOv   = cond.batteryOvervoltage;
  assign faultRep.zone        = zoneCode(cond);

  assign limitState.attached  = cond.inputAttached;
  assign limitState.vinActive = cond.vinLimit;
  assign limitState.iinActive = cond.iinLimit;
  assign limitState.reserved  = 1'b0;
  assign limitState.topup     = cond.topupRunning;
  assign limitState.inputOv   = cond.inputOvervoltage;
  assign limitState.vinMask   = vinMask_reg;
  assign limitState.iinMask   = iinMask_reg;

  assign resetId.restore  = restore_reg;
  assign resetId.partCode = cond.detectVariant ? PART_CODE_DETECT : PART_CODE_PIN;
  assign resetId.reserved = 1'b0;
  assign resetId.revision = REVISION_CODE;

  assign readData =
    (pointer_reg == ADDR_SOURCE_STATE) ? srcState :
    (pointer_reg == ADDR_FAULT)        ? faultRep :
    (pointer_reg == ADDR_LIMIT_MASK)   ? limitState :
    (pointer_reg == ADDR_RESET_ID)     ? resetId :
    READ_UNMAPPED;

  wire sclNow    = busSync[1];
  wire sdaNow    = busSync[0];
  wire sclRise   = sclNow & ~sclPrev_reg;
  wire sclFall   = ~sclNow & sclPrev_reg;
  wire startSeen = sclNow & sclPrev_reg & sdaPrev_reg & ~sdaNow;
  wire stopSeen  = sclNow & sclPrev_reg & ~sdaPrev_reg & sdaNow;
  wire addrMatch = shift_reg[7:1] == TARGET_ADDR;

  wire rxState   = (state_reg == ST_ADDR) | (state_reg == ST_PTR) |
                   (state_reg == ST_WDATA);
  wire countBit  = sclRise & (rxState | (state_reg == ST_RDATA));
  wire ptrLoad   = sclFall & gotByte_reg & (state_reg == ST_PTR);
  // only mask and restore bits take writes
  wire writeByte = sclFall & gotByte_reg & (state_reg == ST_WDATA);
  wire maskWrite = writeByte & (pointer_reg == ADDR_LIMIT_MASK);
  wire rstWrite  = writeByte & (pointer_reg == ADDR_RESET_ID) & shift_reg[7];
  wire loadTx    = sclFall & (((state_reg == ST_ADDR_ACK) & readMode_reg) |
                              ((state_reg == ST_RACK) & masterAck_reg));
  wire shiftTx   = sclFall & (state_reg == ST_RDATA) & ~gotByte_reg;
  wire restoreEnd = restore_reg & (restoreCnt_reg == 4'h1);
  wire ackNext   = (state_next == ST_ADDR_ACK) | (state_next == ST_PTR_ACK) |
                   (state_next == ST_WACK);

  assign txNext = loadTx  ? readData :
                  shiftTx ? {txShift_reg[6:0], 1'b0} :
                  txShift_reg;

  always_comb
  begin
    state_next = state_reg;
    if (startSeen)
      state_next = ST_ADDR;
    else if (stopSeen)
      state_next = ST_IDLE;
    else if (sclFall)
    begin
      case (state_reg)
        ST_IDLE:
          state_next = ST_IDLE;
        ST_ADDR:
          if (gotByte_reg)
            state_next = addrMatch ? ST_ADDR_ACK : ST_IDLE;
        ST_ADDR_ACK:
          state_next = readMode_reg ? ST_RDATA : ST_PTR;
        ST_PTR:
          if (gotByte_reg)
            state_next = ST_PTR_ACK;
        ST_PTR_ACK:
          state_next = ST_WDATA;
        ST_WDATA:
          if (gotByte_reg)
            state_next = ST_WACK;
        ST_WACK:
          state_next = ST_WDATA;
        ST_RDATA:
          if (gotByte_reg)
            state_next = ST_RACK;
        ST_RACK:
          state_next = masterAck_reg ? ST_RDATA : ST_IDLE;
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclPrev_reg  <= 1'b1;
      sdaPrev_reg  <= 1'b1;
      state_reg    <= ST_IDLE;
      sdaDrive_reg <= 1'b0;
      txShift_reg  <= 8'h00;
    end
    else
    begin
      sclPrev_reg  <= sclNow;
      sdaPrev_reg  <= sdaNow;
      state_reg    <= state_next;
      sdaDrive_reg <= ackNext | ((state_next == ST_RDATA) & ~txNext[7]);
      txShift_reg  <= txNext;
    end
  end

  // The counter wraps to zero after each byte, so acks need no reload.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bitCnt_reg  <= 3'h0;
      gotByte_reg <= 1'b0;
      shift_reg   <= 8'h00;
    end
    else if (startSeen)
    begin
      bitCnt_reg  <= 3'h0;
      gotByte_reg <= 1'b0;
    end
    else if (countBit)
    begin
      bitCnt_reg  <= bitCnt_reg + 3'h1;
      gotByte_reg <= bitCnt_reg == 3'h7;
      if (rxState)
        shift_reg <= {shift_reg[6:0], sdaNow};
    end
    else if (sclFall)
      gotByte_reg <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      readMode_reg  <= 1'b0;
      masterAck_reg <= 1'b0;
    end
    else
    begin
      if (sclFall & gotByte_reg & (state_reg == ST_ADDR))
        readMode_reg <= shift_reg[0];
      if (sclRise & (state_reg == ST_RACK))
        masterAck_reg <= ~sdaNow;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pointer_reg <= POINTER_RESET;
    else if (ptrLoad)
      pointer_reg <= shift_reg;
    else if (writeByte | loadTx)
      pointer_reg <= pointer_reg + 8'h01;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      vinMask_reg <= MASK_RESET;
      iinMask_reg <= MASK_RESET;
    end
    else if (rstWrite)
    begin
      vinMask_reg <= MASK_RESET;
      iinMask_reg <= MASK_RESET;
    end
    else if (maskWrite)
    begin
      vinMask_reg <= shift_reg[1];
      iinMask_reg <= shift_reg[0];
    end
  end

  // restore runs a fixed time then clears
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      restore_reg    <= RESTORE_RESET;
      restoreCnt_reg <= 4'h0;
    end
    else if (rstWrite)
    begin
      restore_reg    <= 1'b1;
      restoreCnt_reg <= RESTORE_CNT_INIT;
    end
    else if (restore_reg)
    begin
      restore_reg    <= ~restoreEnd;
      restoreCnt_reg <= restoreCnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      vinPrev_reg <= 1'b0;
      iinPrev_reg <= 1'b0;
      vinIrq_reg  <= 1'b0;
      iinIrq_reg  <= 1'b0;
    end
    else
    begin
      vinPrev_reg <= cond.vinLimit;
      iinPrev_reg <= cond.iinLimit;
      vinIrq_reg  <= cond.vinLimit & ~vinPrev_reg & ~vinMask_reg;
      iinIrq_reg  <= cond.iinLimit & ~iinPrev_reg & ~iinMask_reg;
    end
  end

  // Open-drain line: only ever pulls low, the bus pull-up gives the one.
  assign sdaOut           = 1'b0;
  assign sdaOe            = sdaDrive_reg;
  assign vinLimitIrqPulse = vinIrq_reg;
  assign iinLimitIrqPulse = iinIrq_reg;
  assign defaultsRestore  = restore_reg;

endmodule

// >>> include/charger_regs_pkg.sv
// Purpose: Shared constants, codes and layouts for the charger status registers.
// Assumes: 200 MHz clock; registers reached over the two-wire serial port.
// Notes: Each register layout struct fixes its field positions, msb first.
// Behaviour
// - Detecting variant reports source codes 001,010,011,101,110 and 111 for OTG.
// - Pin variant reports 000 none, 001 pin high, 010 pin low, 111 OTG.
// - Current limit is shown elsewhere, never inside the source type field.
// - Charge phase 00 idle, 01 pre-charge, 10 fast, 11 termination.
// - Supply ok and thermal regulation flags follow their conditions.
// - System floor flag is 1 while rail held at minimum system voltage.
// - Watchdog flag is 1 after the register watchdog has expired.
// - OTG fault flag is 1 when boost cannot start or run.
// - Charge fault 00 normal, 01 input, 10 thermal shutdown, 11 timer.
// - Battery overvoltage flag is 1 while overvoltage is detected.
// - Charge mode thermistor zones 000,010,011,101,110.
// - Boost mode thermistor zones only 000, 101 and 110.
// - Input attached flag is 1 while a qualified input is present.
// - Voltage and current limiting flags follow their limiting loops.
// - Top-up flag is 1 while the top-off timer counts.
// - Input overvoltage flag is 1 while in input overvoltage.
// - Voltage limit mask 1 suppresses its entry pulse; defaults 0.
// - Current limit mask 1 suppresses its entry pulse; defaults 0.
// - Writing 1 to restore bit restores defaults and restarts safety timer.
// - Restore bit clears itself once the restore completes.
package charger_regs_pkg;

  localparam logic [7:0] ADDR_SOURCE_STATE = 8'h08;
  localparam logic [7:0] ADDR_FAULT        = 8'h09;
  localparam logic [7:0] ADDR_LIMIT_MASK   = 8'h0A;
  localparam logic [7:0] ADDR_RESET_ID     = 8'h0B;
  localparam logic [7:0] READ_UNMAPPED     = 8'h00;
  localparam logic [6:0] TARGET_ADDR_DEF   = 7'h3C;

  localparam logic       MASK_RESET        = 1'b0;
  localparam logic       RESTORE_RESET     = 1'b0;
  localparam logic [7:0] POINTER_RESET     = 8'h00;

  // Part and revision values are arbitrary.
  localparam logic [3:0] PART_CODE_DETECT  = 4'hA;
  localparam logic [3:0] PART_CODE_PIN     = 4'h5;
  localparam logic [1:0] REVISION_CODE     = 2'h2;

  localparam int         CLOCK_PERIOD_NS   = 5;
  localparam int         RESTORE_TIME_NS   = 40;
  localparam int         RESTORE_CYCLES    =
    (RESTORE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] RESTORE_CNT_INIT  = 4'(RESTORE_CYCLES);

  localparam logic [2:0] SRC_NONE    = 3'h0;
  localparam logic [2:0] SRC_SDP     = 3'h1;
  localparam logic [2:0] SRC_CDP     = 3'h2;
  localparam logic [2:0] SRC_ADAPTER = 3'h2;
  localparam logic [2:0] SRC_DCP     = 3'h3;
  localparam logic [2:0] SRC_UNKNOWN = 3'h5;
  localparam logic [2:0] SRC_NONSTD  = 3'h6;
  localparam logic [2:0] SRC_OTG     = 3'h7;

  localparam logic [1:0] PHASE_IDLE  = 2'h0;
  localparam logic [1:0] PHASE_PRE   = 2'h1;
  localparam logic [1:0] PHASE_FAST  = 2'h2;
  localparam logic [1:0] PHASE_DONE  = 2'h3;

  localparam logic [1:0] FAULT_NONE    = 2'h0;
  localparam logic [1:0] FAULT_INPUT   = 2'h1;
  localparam logic [1:0] FAULT_THERMAL = 2'h2;
  localparam logic [1:0] FAULT_TIMER   = 2'h3;

  localparam logic [2:0] ZONE_NORMAL = 3'h0;
  localparam logic [2:0] ZONE_WARM   = 3'h2;
  localparam logic [2:0] ZONE_COOL   = 3'h3;
  localparam logic [2:0] ZONE_COLD   = 3'h5;
  localparam logic [2:0] ZONE_HOT    = 3'h6;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_SDP, KIND_CDP, KIND_DCP, KIND_UNKNOWN, KIND_NONSTD
  } source_kind_type;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_PTR      = 9'h008,
    ST_PTR_ACK  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_WACK     = 9'h040,
    ST_RDATA    = 9'h080,
    ST_RACK     = 9'h100
  } serial_state_type;

  typedef struct packed {
    logic            detectVariant;
    source_kind_type detectedKind;
    logic            sourceSelectPin;
    logic            otgActive;
    logic            inputAttached;
    logic            charging;
    logic            belowPrecharge;
    logic            chargeDone;
    logic            powerGood;
    logic            thermalReg;
    logic            sysFloorReg;
    logic            wdtExpired;
    logic            boostFault;
    logic            inputFault;
    logic            thermalShutdown;
    logic            safetyTimerExpired;
    logic            batteryOvervoltage;
    logic            boostMode;
    logic            zoneWarm;
    logic            zoneCool;
    logic            zoneCold;
    logic            zoneHot;
    logic            vinLimit;
    logic            iinLimit;
    logic            topupRunning;
    logic            inputOvervoltage;
  } charger_conditions_type;

  typedef struct packed {
    logic [2:0] sourceType;
    logic [1:0] phase;
    logic       supplyOk;
    logic       thermalReg;
    logic       sysFloorReg;
  } source_state_type;

  typedef struct packed {
    logic       wdtExpiry;
    logic       otgFault;
    logic [1:0] chargeFault;
    logic       batteryOv;
    logic [2:0] zone;
  } fault_report_type;

  typedef struct packed {
    logic attached;
    logic vinActive;
    logic iinActive;
    logic reserved;
    logic topup;
    logic inputOv;
    logic vinMask;
    logic iinMask;
  } limit_state_type;

  typedef struct packed {
    logic       restore;
    logic [3:0] partCode;
    logic       reserved;
    logic [1:0] revision;
  } reset_id_type;

endpackage

// >>> rtl/line_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous levels.
// Assumes: Each bit is an independent level; no multi-bit coherence.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module line_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import charger_regs_pkg::*;

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule

// >>> verif/charger_status_fault_regs_checker.sv
// Purpose: Port-level timing checks for the charger status registers.
// Assumes: Serial master holds scl phases of eight clocks or more.
// Notes: Bound into every instance of the register block.
`timescale 1ns/10ps
module charger_status_fault_regs_checker
  import charger_regs_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   scl,
  input wire logic                   sdaIn,
  input wire logic                   sdaOut,
  input wire logic                   sdaOe,
  input wire charger_conditions_type conditions,
  input wire logic                   vinLimitIrqPulse,
  input wire logic                   iinLimitIrqPulse,
  input wire logic                   defaultsRestore
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_restoreHold;
    defaultsRestore [*8] ##1 !defaultsRestore;
  endsequence
  sequence s_oeSteady;
    $stable(sdaOe) [*4];
  endsequence

  property p_restoreLen;
    $rose(defaultsRestore) |-> s_restoreHold;
  endproperty
  a_restoreLen: assert property (p_restoreLen)
    else $error("restore level has the wrong length");
  property p_restoreAck;
    $rose(defaultsRestore) |-> $rose(sdaOe) && !scl;
  endproperty
  a_restoreAck: assert property (p_restoreAck)
    else $error("restore did not start with the data acknowledge");
  property p_oeLow;
    $changed(sdaOe) |-> !scl && !$past(scl) && !$past(scl, 2);
  endproperty
  a_oeLow: assert property (p_oeLow)
    else $error("data line changed outside the clock low phase");
  property p_oeHigh;
    $rose(scl) |-> s_oeSteady;
  endproperty
  a_oeHigh: assert property (p_oeHigh)
    else $error("data line moved while clock high");
  property p_openDrain;
    sdaOe |-> !sdaOut;
  endproperty
  a_openDrain: assert property (p_openDrain)
    else $error("data line driven high");
  property p_vinOne;
    vinLimitIrqPulse |=> !vinLimitIrqPulse;
  endproperty
  a_vinOne: assert property (p_vinOne)
    else $error("voltage limit pulse longer than one clock");
  property p_iinOne;
    iinLimitIrqPulse |=> !iinLimitIrqPulse;
  endproperty
  a_iinOne: assert property (p_iinOne)
    else $error("current limit pulse longer than one clock");
  property p_vinCause;
    vinLimitIrqPulse |-> conditions.vinLimit && $past(conditions.vinLimit, 2);
  endproperty
  a_vinCause: assert property (p_vinCause)
    else $error("voltage limit pulse without limiting");
  property p_iinCause;
    iinLimitIrqPulse |-> conditions.iinLimit && $past(conditions.iinLimit, 2);
  endproperty
  a_iinCause: assert property (p_iinCause)
    else $error("current limit pulse without limiting");
endmodule

bind charger_status_fault_regs charger_status_fault_regs_checker chk (
  .clock, .rst, .scl, .sdaIn, .sdaOut, .sdaOe, .conditions,
  .vinLimitIrqPulse, .iinLimitIrqPulse, .defaultsRestore
);

// >>> verif/serial_host_model.sv
// Purpose: Two-wire serial master that reads and writes device registers.
// Assumes: Line pulled up; each bit takes nineteen clocks.
// Notes: Data changes five clocks after the clock falls to clear device hold.
`timescale 1ns/10ps
module serial_host_model
  import charger_regs_pkg::*;
(
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaHost
);
  initial
  begin
    scl = 1'b1;
    sdaHost = 1'b1;
  end

  task automatic step(input logic s, input logic d);
    repeat (5) @(posedge clock);
    scl <= s;
    sdaHost <= d;
  endtask

  task automatic put_bit(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    repeat (4) @(posedge clock);
    r = sda;
    step(1'b0, b);
  endtask

  task automatic start_cond();
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask

  task automatic stop_cond();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], r[i]);
    put_bit(m, a);
  endtask

  task automatic access(input logic rd, input logic [7:0] p, input logic [7:0] w,
                        output logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    start_cond();
    xfer({TARGET_ADDR_DEF, 1'b0}, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    if (rd)
      start_cond();
    xfer(rd ? {TARGET_ADDR_DEF, 1'b1} : w, 1'b1, d, a2);
    if (rd)
      xfer(8'hFF, 1'b1, d, r[0]);
    stop_cond();
    nak = a0 | a1 | a2;
  endtask
endmodule

// >>> verif/charger_status_fault_regs_tb.sv
// Purpose: Self-checking bench for the charger status registers.
// Assumes: Host model drives the serial port; conditions set by the bench.
// Notes: Expected bytes are built from the field layout by hand.
`timescale 1ns/10ps
module charger_status_fault_regs_tb;
  import charger_regs_pkg::*;
  logic                   clock = 1'b0;
  logic                   rst = 1'b1;
  logic                   scl;
  logic                   sdaHost;
  logic                   sdaOut;
  logic                   sdaOe;
  logic                   vinP;
  logic                   iinP;
  logic                   restoreOut;
  charger_conditions_type cond = '0;
  wire                    sda = sdaHost & ~sdaOe;
  int                     n_fail = 0;
  int                     n_tests = 0;
  int                     cycles = 0;
  int                     vinCnt = 0;
  int                     iinCnt = 0;
  int                     restCnt = 0;

  serial_host_model host (.clock(clock), .sda(sda), .scl(scl), .sdaHost(sdaHost));
  charger_status_fault_regs #(.TARGET_ADDR(TARGET_ADDR_DEF)) uut (
    .clock(clock), .rst(rst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .conditions(cond), .vinLimitIrqPulse(vinP),
    .iinLimitIrqPulse(iinP), .defaultsRestore(restoreOut)
  );

  always #2.5 clock = ~clock;

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ceiling is about twice the length of the planned traffic.
  always @(posedge clock)
  begin
    cycles++;
    vinCnt += vinP;
    iinCnt += iinP;
    restCnt += restoreOut;
    if (cycles == 60000)
    begin
      n_fail++;
      $display("Error at %0t: run did not finish", $time);
      close_out();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_io(input logic rd, input logic [7:0] p, input logic [7:0] w,
                        input logic [7:0] exp);
    logic [7:0] d;
    logic       nak;
    host.access(rd, p, w, d, nak);
    check({7'h00, nak}, 8'h00);
    if (rd)
      check(d, exp);
  endtask

  task automatic case_chk(input logic [7:0] p, input charger_conditions_type c,
                          input logic [7:0] exp);
    @(posedge clock);
    cond <= c;
    reg_io(1'b1, p, 8'h00, exp);
  endtask

  task automatic t_ident();
    charger_conditions_type c = '0;
    case_chk(ADDR_RESET_ID, c, {1'b0, PART_CODE_PIN, 1'b0, REVISION_CODE});
    case_chk(ADDR_LIMIT_MASK, c, 8'h00);
    c.detectVariant = 1'b1;
    case_chk(ADDR_RESET_ID, c, {1'b0, PART_CODE_DETECT, 1'b0, REVISION_CODE});
    $display("t_ident done");
  endtask

  task automatic t_source();
    charger_conditions_type c = '0;
    logic [2:0]             codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    c.detectVariant = 1'b1;
    c.inputAttached = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      c.detectedKind = source_kind_type'(k + 1);
      case_chk(ADDR_SOURCE_STATE, c, {codes[k], 5'h00});
    end
    case_chk(ADDR_LIMIT_MASK, c, 8'h80);
    c.otgActive = 1'b1;
    case_chk(ADDR_SOURCE_STATE, c, 8'hE0);
    c.detectVariant = 1'b0;
    case_chk(ADDR_SOURCE_STATE, c, 8'hE0);
    c.otgActive = 1'b0;
    c.sourceSelectPin = 1'b1;
    case_chk(ADDR_SOURCE_STATE, c, 8'h20);
    c.sourceSelectPin = 1'b0;
    case_chk(ADDR_SOURCE_STATE, c, 8'h40);
    c.inputAttached = 1'b0;
    case_chk(ADDR_SOURCE_STATE, c, 8'h00);
    $display("t_source done");
  endtask

  task automatic t_phase();
    charger_conditions_type c = '0;
    c.belowPrecharge = 1'b1;
    case_chk(ADDR_SOURCE_STATE, c, 8'h00);
    c.charging = 1'b1;
    c.powerGood = 1'b1;
    case_chk(ADDR_SOURCE_STATE, c, 8'h0C);
    c = '0;
    c.charging = 1'b1;
    c.thermalReg = 1'b1;
    case_chk(ADDR_SOURCE_STATE, c, 8'h12);
    c.chargeDone = 1'b1;
    c.thermalReg = 1'b0;
    c.sysFloorReg = 1'b1;
    case_chk(ADDR_SOURCE_STATE, c, 8'h19);
    $display("t_phase done");
  endtask

  task automatic t_fault();
    charger_conditions_type c = '0;
    c.wdtExpired = 1'b1;
    c.zoneWarm = 1'b1;
    case_chk(ADDR_FAULT, c, 8'h82);
    c.boostMode = 1'b1;
    case_chk(ADDR_FAULT, c, 8'h80);
    c.zoneCool = 1'b1;
    c.boostMode = 1'b0;
    case_chk(ADDR_FAULT, c, 8'h82);
    c = '0;
    c.boostFault = 1'b1;
    c.inputFault = 1'b1;
    c.thermalShutdown = 1'b1;
    c.zoneCool = 1'b1;
    case_chk(ADDR_FAULT, c, 8'h53);
    c = '0;
    c.thermalShutdown = 1'b1;
    c.batteryOvervoltage = 1'b1;
    c.zoneCold = 1'b1;
    case_chk(ADDR_FAULT, c, 8'h2D);
    c = '0;
    c.safetyTimerExpired = 1'b1;
    c.zoneHot = 1'b1;
    c.boostMode = 1'b1;
    case_chk(ADDR_FAULT, c, 8'h36);
    $display("t_fault done");
  endtask

  task automatic t_limits();
    charger_conditions_type c = '0;
    c.inputAttached = 1'b1;
    c.vinLimit = 1'b1;
    c.topupRunning = 1'b1;
    case_chk(ADDR_LIMIT_MASK, c, 8'hC8);
    c.vinLimit = 1'b0;
    case_chk(ADDR_LIMIT_MASK, c, 8'h88);
    c = '0;
    c.iinLimit = 1'b1;
    c.inputOvervoltage = 1'b1;
    case_chk(ADDR_LIMIT_MASK, c, 8'h24);
    check({vinCnt[3:0], iinCnt[3:0]}, 8'h11);
    reg_io(1'b0, ADDR_LIMIT_MASK, 8'hFF, 8'h00);
    case_chk(ADDR_LIMIT_MASK, '0, 8'h03);
    c = '0;
    c.vinLimit = 1'b1;
    c.iinLimit = 1'b1;
    case_chk(ADDR_LIMIT_MASK, c, 8'h63);
    check({vinCnt[3:0], iinCnt[3:0]}, 8'h11);
    $display("t_limits done");
  endtask

  task automatic t_restore();
    reg_io(1'b0, ADDR_SOURCE_STATE, 8'hFF, 8'h00);
    case_chk(ADDR_SOURCE_STATE, '0, 8'h00);
    reg_io(1'b0, ADDR_RESET_ID, 8'h80, 8'h00);
    check(8'(restCnt), 8'h08);
    reg_io(1'b1, ADDR_LIMIT_MASK, 8'h00, 8'h00);
    reg_io(1'b1, ADDR_RESET_ID, 8'h00, {1'b0, PART_CODE_PIN, 1'b0, REVISION_CODE});
    reg_io(1'b1, 8'h0C, 8'h00, 8'h00);
    $display("t_restore done");
  endtask

  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    t_ident();
    t_source();
    t_phase();
    t_fault();
    t_limits();
    t_restore();
    close_out();
  end
endmodule
